/* File: vrs_pkg.sv */
// Constants, register map and types shared by the set-point supervisor.
package vrs_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int SKEW_NS = 200;
  localparam int SKEW_CYC = (SKEW_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_US = 100;
  localparam int BLANK_CYC = BLANK_US * CLK_MHZ;
  localparam int OFF_US = 5;
  localparam int OFF_CYC = OFF_US * CLK_MHZ;
  localparam int GOOD_DELAY_US = 1000;
  localparam int GOOD_DELAY_CYC = GOOD_DELAY_US * CLK_MHZ;
  localparam int STEP_UV = 6250;
  localparam int OFS_MAX_UV = 193750;
  localparam int OFS_MAX = OFS_MAX_UV / STEP_UV;
  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TARGET = 8'h21;
  localparam logic [7:0] ADDR_SHED = 8'hD1;
  localparam logic [7:0] ADDR_CFG1A = 8'hD2;
  localparam logic [7:0] ADDR_CFG1B = 8'hD3;
  localparam logic [7:0] ADDR_RATE = 8'hD6;
  localparam logic [7:0] ADDR_TRIM = 8'hDB;
  localparam logic [7:0] ADDR_CAL = 8'hDC;
  localparam logic [7:0] ADDR_GHI = 8'hE0;
  localparam logic [7:0] ADDR_GLO = 8'hE1;
  localparam logic [7:0] ADDR_STAT = 8'hEF;
  localparam int BUS_SEL_BIT = 3;
  localparam int OFS_SIGN_BIT = 5;
  localparam int SHED_LSB = 6;
  localparam logic [7:0] RATE_RST = 8'h02;
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [1:0] SHED_TWO = 2'h1;
  localparam logic [7:0] OFF_CODE_A = 8'h00;
  localparam logic [7:0] OFF_CODE_B = 8'h01;
  localparam logic [7:0] NO_CPU_CODE = 8'hFF;
  localparam logic [3:0] LPS_ONE = 4'h1;
  localparam logic [3:0] LPS_TWO = 4'h5;
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_RAMP = 4'h2,
    ST_DELAY = 4'h4,
    ST_ON = 4'h8
  } vrs_state_e;
endpackage : vrs_pkg

/* File: vrs_tgt_if.sv */
// Target request and slew status carried between supervisor and slew unit.
`timescale 1ns/10ps
`default_nettype none
interface vrs_tgt_if;
  logic [7:0] req_code;
  logic [2:0] rate_sel;
  logic hold;
  logic [7:0] cur_code;
  logic at_target;
  modport ctrl (output req_code, output rate_sel, output hold,
                input cur_code, input at_target);
  modport slew (input req_code, input rate_sel, input hold,
                output cur_code, output at_target);
endinterface : vrs_tgt_if
`default_nettype wire

/* File: vrs_glitch_filter.sv */
// Skew filter that accepts a target code only after it has been stable.
`timescale 1ns/10ps
`default_nettype none
module vrs_glitch_filter #(
  parameter int W = 8,
  parameter int HOLD = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] code
);
  logic [W-1:0] last_reg;
  logic [7:0] cnt_reg;

  // A toggle restarts the count, so skewed bits never reach the output.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_reg <= '0;
      cnt_reg <= 8'h00;
      code <= '0;
    end
    else if (raw != last_reg)
    begin
      last_reg <= raw;
      cnt_reg <= 8'h00;
    end
    else if (cnt_reg < 8'(HOLD))
    begin
      cnt_reg <= cnt_reg + 8'h01;
    end
    else
    begin
      code <= last_reg;
    end
  end
endmodule : vrs_glitch_filter
`default_nettype wire

/* File: vrs_slew.sv */
// Moves the working target one code step at a time at the selected rate, or straight to the request while held.
`timescale 1ns/10ps
`default_nettype none
module vrs_slew (
  input wire logic clk,
  input wire logic rst_n,
  vrs_tgt_if.slew t
);
  logic [7:0] cur_reg;
  logic [7:0] cnt_reg;

  // Rate code n gives 1+2n V/ms; a step period rounds down, never below one.
  function automatic logic [7:0] step_cyc(input logic [2:0] r);
    int c;
    c = (vrs_pkg::STEP_UV * vrs_pkg::CLK_MHZ) / (1000 * (1 + 2 * int'(r)));
    if (c < 1)
      c = 1;
    return 8'(c);
  endfunction : step_cyc

  assign t.cur_code = cur_reg;
  assign t.at_target = (cur_reg == t.req_code);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_reg <= 8'h00;
      cnt_reg <= 8'h00;
    end
    else if (t.hold)
    begin
      cur_reg <= t.req_code;
      cnt_reg <= 8'h00;
    end
    else if (cur_reg == t.req_code)
    begin
      cnt_reg <= 8'h00;
    end
    else if (cnt_reg >= step_cyc(t.rate_sel) - 8'h01)
    begin
      cnt_reg <= 8'h00;
      cur_reg <= (t.req_code > cur_reg) ? cur_reg + 8'h01 : cur_reg - 8'h01;
    end
    else
    begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule : vrs_slew
`default_nettype wire

/* File: vrs_supervisor.sv */
// Top of the regulator set-point and supervision logic.
`timescale 1ns/10ps
`default_nettype none
module vrs_supervisor #(
  parameter int GOOD_DELAY_CYC = vrs_pkg::GOOD_DELAY_CYC,
  parameter int NORMAL_PHASES = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] target_code,
  input wire logic low_power_state_n,
  input wire logic en_ok,
  input wire logic undervoltage_lockout_ok,
  input wire logic ss_done,
  input wire logic out_in_window,
  input wire logic out_over_limit,
  input wire logic out_below_release,
  input wire logic oc_fault,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [7:0] target_out,
  output logic [6:0] offset_steps,
  output logic [1:0] good_high_sel,
  output logic [2:0] good_low_sel,
  output logic power_good_out,
  output logic pwm_force_low,
  output logic [3:0] phase_enable,
  output logic main_phase_disable_n,
  output logic shed_phase_disable_n,
  output logic ctrl_running
);
  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic rst_s_n;
  logic [7:0] code_s1;
  logic [7:0] code_s2;
  logic lps_s1;
  logic lps_s2;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_s_n = rst_pipe[1];

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      code_s1 <= 8'h00;
      code_s2 <= 8'h00;
      lps_s1 <= 1'b1;
      lps_s2 <= 1'b1;
    end
    else
    begin
      code_s1 <= target_code;
      code_s2 <= code_s1;
      lps_s1 <= low_power_state_n;
      lps_s2 <= lps_s1;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] tgt_cmd_reg;
  logic [7:0] shed_reg;
  logic [7:0] cfg1a_reg;
  logic [7:0] cfg1b_reg;
  logic [7:0] rate_reg;
  logic [7:0] trim_reg;
  logic [7:0] cal_reg;
  logic [7:0] ghi_reg;
  logic [7:0] glo_reg;
  logic [7:0] status;

  // These survive enable cycling; only a supply reset returns them to default.
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      tgt_cmd_reg <= vrs_pkg::ZERO_RST;
      shed_reg <= vrs_pkg::ZERO_RST;
      cfg1a_reg <= vrs_pkg::ZERO_RST;
      cfg1b_reg <= vrs_pkg::ZERO_RST;
      rate_reg <= vrs_pkg::RATE_RST;
      trim_reg <= vrs_pkg::ZERO_RST;
      cal_reg <= vrs_pkg::ZERO_RST;
      ghi_reg <= vrs_pkg::ZERO_RST;
      glo_reg <= vrs_pkg::ZERO_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        vrs_pkg::ADDR_TARGET: tgt_cmd_reg <= reg_wdata;
        vrs_pkg::ADDR_SHED: shed_reg <= reg_wdata;
        vrs_pkg::ADDR_CFG1A: cfg1a_reg <= reg_wdata;
        vrs_pkg::ADDR_CFG1B: cfg1b_reg <= reg_wdata;
        vrs_pkg::ADDR_RATE: rate_reg <= reg_wdata;
        vrs_pkg::ADDR_TRIM: trim_reg <= reg_wdata;
        vrs_pkg::ADDR_CAL: cal_reg <= reg_wdata;
        vrs_pkg::ADDR_GHI: ghi_reg <= reg_wdata;
        vrs_pkg::ADDR_GLO: glo_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        vrs_pkg::ADDR_TARGET: reg_rdata <= tgt_cmd_reg;
        vrs_pkg::ADDR_SHED: reg_rdata <= shed_reg;
        vrs_pkg::ADDR_CFG1A: reg_rdata <= cfg1a_reg;
        vrs_pkg::ADDR_CFG1B: reg_rdata <= cfg1b_reg;
        vrs_pkg::ADDR_RATE: reg_rdata <= rate_reg;
        vrs_pkg::ADDR_TRIM: reg_rdata <= trim_reg;
        vrs_pkg::ADDR_CAL: reg_rdata <= cal_reg;
        vrs_pkg::ADDR_GHI: reg_rdata <= ghi_reg;
        vrs_pkg::ADDR_GLO: reg_rdata <= glo_reg;
        vrs_pkg::ADDR_STAT: reg_rdata <= status;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output offset
  // ----------------------------------------------------------------
  function automatic logic signed [7:0] sm_steps(input logic [7:0] c);
    logic signed [7:0] m;
    m = signed'({3'h0, c[vrs_pkg::OFS_SIGN_BIT-1:0]});
    return c[vrs_pkg::OFS_SIGN_BIT] ? -m : m;
  endfunction : sm_steps

  logic signed [7:0] ofs_sum;
  logic signed [7:0] ofs_lim;
  assign ofs_sum = sm_steps(trim_reg) + sm_steps(cal_reg);
  assign ofs_lim = 8'(vrs_pkg::OFS_MAX);

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      offset_steps <= 7'h00;
    else if (ofs_sum > ofs_lim)
      offset_steps <= ofs_lim[6:0];
    else if (ofs_sum < -ofs_lim)
      offset_steps <= 7'(-ofs_lim);
    else
      offset_steps <= ofs_sum[6:0];
  end

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      good_high_sel <= 2'h0;
      good_low_sel <= 3'h0;
    end
    else
    begin
      good_high_sel <= ghi_reg[1:0];
      good_low_sel <= glo_reg[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Target selection, filtering and blanking
  // ----------------------------------------------------------------
  logic [7:0] pin_code;
  logic bus_sel;
  logic [7:0] req_code;
  logic [7:0] req_reg;
  logic [10:0] blank_cnt;
  logic blank;
  logic no_cpu;
  logic is_off;
  logic [6:0] off_cnt;
  logic off_shut;

  vrs_glitch_filter #(
    .W(8),
    .HOLD(vrs_pkg::SKEW_CYC)
  ) u_filt (
    .clk(clk),
    .rst_n(rst_s_n),
    .raw(code_s2),
    .code(pin_code)
  );

  // The bus target needs both select bits, so one stray write cannot steal it.
  assign bus_sel = cfg1a_reg[vrs_pkg::BUS_SEL_BIT] & cfg1b_reg[vrs_pkg::BUS_SEL_BIT];
  assign req_code = bus_sel ? tgt_cmd_reg : pin_code;
  assign no_cpu = (pin_code == vrs_pkg::NO_CPU_CODE);
  assign is_off = (pin_code == vrs_pkg::OFF_CODE_A) || (pin_code == vrs_pkg::OFF_CODE_B);
  assign blank = (blank_cnt != 11'h000);

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      req_reg <= 8'h00;
      blank_cnt <= 11'h000;
    end
    else
    begin
      req_reg <= req_code;
      if (req_code != req_reg)
        blank_cnt <= 11'(vrs_pkg::BLANK_CYC);
      else if (blank)
        blank_cnt <= blank_cnt - 11'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      off_cnt <= 7'h00;
      off_shut <= 1'b0;
    end
    else if (!is_off)
    begin
      off_cnt <= 7'h00;
      off_shut <= 1'b0;
    end
    else if (off_cnt < 7'(vrs_pkg::OFF_CYC))
      off_cnt <= off_cnt + 7'h01;
    else
      off_shut <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Enable, lockout and fault latches
  // ----------------------------------------------------------------
  logic supply_ok;
  logic oc_latch;
  logic cb_reg;
  logic run_ok;

  assign supply_ok = en_ok & undervoltage_lockout_ok;
  assign run_ok = supply_ok & ~off_shut & ~oc_latch;

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      oc_latch <= 1'b0;
    else if (oc_fault && supply_ok)
      oc_latch <= 1'b1;
    else if (!supply_ok)
      oc_latch <= 1'b0;
  end

  // The clamp ignores the limit while blanked, but once set it holds
  // until the output has truly discharged or the supply is lost.
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      cb_reg <= 1'b0;
    else if (out_over_limit && !blank && supply_ok)
      cb_reg <= 1'b1;
    else if (out_below_release || !supply_ok)
      cb_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Slew unit
  // ----------------------------------------------------------------
  vrs_tgt_if tif ();
  assign tif.req_code = req_code;
  assign tif.rate_sel = rate_reg[2:0];
  assign tif.hold = ~run_ok;

  vrs_slew u_slew (
    .clk(clk),
    .rst_n(rst_s_n),
    .t(tif.slew)
  );
  assign target_out = tif.cur_code;

  // ----------------------------------------------------------------
  // Start-up sequence and power good
  // ----------------------------------------------------------------
  vrs_pkg::vrs_state_e st_reg;
  logic [31:0] dly_cnt;

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      st_reg <= vrs_pkg::ST_OFF;
      dly_cnt <= 32'h0;
    end
    else if (!run_ok)
    begin
      st_reg <= vrs_pkg::ST_OFF;
      dly_cnt <= 32'h0;
    end
    else
    begin
      case (st_reg)
        vrs_pkg::ST_OFF: st_reg <= vrs_pkg::ST_RAMP;
        vrs_pkg::ST_RAMP:
        begin
          dly_cnt <= 32'h0;
          if (ss_done && tif.at_target && !blank)
            st_reg <= vrs_pkg::ST_DELAY;
        end
        vrs_pkg::ST_DELAY:
        begin
          if (dly_cnt >= 32'(GOOD_DELAY_CYC - 1))
            st_reg <= vrs_pkg::ST_ON;
          else
            dly_cnt <= dly_cnt + 32'h1;
        end
        vrs_pkg::ST_ON: st_reg <= vrs_pkg::ST_ON;
        default: st_reg <= vrs_pkg::ST_OFF;
      endcase
    end
  end

  // During blanking the last verdict is kept rather than re-judged.
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      power_good_out <= 1'b0;
    else if (!run_ok || no_cpu || st_reg != vrs_pkg::ST_ON)
      power_good_out <= 1'b0;
    else if (!blank)
      power_good_out <= out_in_window;
  end

  // ----------------------------------------------------------------
  // PWM gating and phase control
  // ----------------------------------------------------------------
  logic [3:0] norm_mask;
  logic [3:0] lps_mask;
  logic force_low;

  assign norm_mask = 4'((5'h01 << NORMAL_PHASES) - 5'h01);
  assign lps_mask = (shed_reg[7:vrs_pkg::SHED_LSB] == vrs_pkg::SHED_TWO
                     && NORMAL_PHASES == 4) ? vrs_pkg::LPS_TWO : vrs_pkg::LPS_ONE;
  assign force_low = ~run_ok | cb_reg | (st_reg == vrs_pkg::ST_OFF);

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      pwm_force_low <= 1'b1;
      phase_enable <= 4'h0;
      main_phase_disable_n <= 1'b0;
      shed_phase_disable_n <= 1'b0;
      ctrl_running <= 1'b0;
    end
    else
    begin
      pwm_force_low <= force_low;
      if (force_low)
        phase_enable <= 4'h0;
      else if (!lps_s2)
        phase_enable <= lps_mask & norm_mask;
      else
        phase_enable <= norm_mask;
      main_phase_disable_n <= run_ok;
      shed_phase_disable_n <= run_ok & lps_s2;
      ctrl_running <= run_ok;
    end
  end

  assign status = {1'b0, tif.at_target, blank, off_shut, oc_latch, cb_reg,
                   power_good_out, run_ok};
endmodule : vrs_supervisor
`default_nettype wire

/* File: vrs_supervisor_sva.sv */
// Concurrent assertions on the set-point supervisor ports.
`timescale 1ns/10ps
`default_nettype none
module vrs_supervisor_sva #(
  parameter int GOOD_DELAY_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] target_code,
  input wire logic low_power_state_n,
  input wire logic en_ok,
  input wire logic undervoltage_lockout_ok,
  input wire logic ss_done,
  input wire logic out_below_release,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic [6:0] offset_steps,
  input wire logic power_good_out,
  input wire logic pwm_force_low,
  input wire logic [3:0] phase_enable,
  input wire logic main_phase_disable_n,
  input wire logic shed_phase_disable_n,
  input wire logic ctrl_running
);
  // ----
  // Helper counters
  // ----
  // Held at 16'hFFFF while stopped, so a restart is not taken for a change.
  logic [15:0] since_reg;
  logic [15:0] run_reg;
  logic [7:0] prev_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_reg <= 8'h00;
    else
      prev_reg <= target_code;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      since_reg <= 16'hFFFF;
    else if (!ctrl_running)
      since_reg <= 16'hFFFF;
    else if (target_code != prev_reg)
      since_reg <= 16'h0000;
    else if (since_reg != 16'hFFFF)
      since_reg <= since_reg + 16'h0001;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      run_reg <= 16'h0000;
    else if (!ctrl_running)
      run_reg <= 16'h0000;
    else if (run_reg != 16'hFFFF)
      run_reg <= run_reg + 16'h0001;
  end
  // ----
  // Properties
  // ----
  sequence supply_lost;
    (!(en_ok && undervoltage_lockout_ok))[*3];
  endsequence
  sequence pg_rises;
    !power_good_out ##1 power_good_out;
  endsequence
  off_outputs_a: assert property (
    supply_lost |-> !power_good_out && pwm_force_low && !main_phase_disable_n
      && !shed_phase_disable_n)
    else $error("outputs on without supply");
  pg_delay_a: assert property (
    pg_rises |-> $past(ss_done) && run_reg > GOOD_DELAY_CYC)
    else $error("early power good");
  pg_blank_a: assert property (
    pg_rises |-> since_reg >= vrs_pkg::BLANK_CYC)
    else $error("power good in blanking");
  no_cpu_a: assert property (
    (target_code == vrs_pkg::NO_CPU_CODE)[*8] |=> !power_good_out)
    else $error("power good on no-cpu code");
  crowbar_hold_a: assert property (
    pwm_force_low && ctrl_running && !out_below_release |=> pwm_force_low)
    else $error("crowbar released early");
  shed_low_a: assert property (
    (!low_power_state_n && ctrl_running)[*4] |=> !shed_phase_disable_n)
    else $error("shed disable high");
  lp_phases_a: assert property (
    (ctrl_running && !shed_phase_disable_n)[*2] |-> phase_enable inside
      {vrs_pkg::LPS_ONE, vrs_pkg::LPS_TWO})
    else $error("wrong low power phases");
  offset_clamp_a: assert property (
    $signed(offset_steps) <= 7'sh1F && $signed(offset_steps) >= -7'sh1F)
    else $error("offset beyond clamp");
  unmapped_read_a: assert property (
    reg_rd && !(reg_addr inside {8'h21, 8'hD1, 8'hD2, 8'hD3, 8'hD6, 8'hDB,
      8'hDC, 8'hE0, 8'hE1, 8'hEF}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
endmodule : vrs_supervisor_sva
bind vrs_supervisor vrs_supervisor_sva #(.GOOD_DELAY_CYC(GOOD_DELAY_CYC)) u_sva (
  .clk(clk), .rst_n(rst_n), .target_code(target_code),
  .low_power_state_n(low_power_state_n), .en_ok(en_ok), .undervoltage_lockout_ok(undervoltage_lockout_ok),
  .ss_done(ss_done), .out_below_release(out_below_release), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .offset_steps(offset_steps),
  .power_good_out(power_good_out), .pwm_force_low(pwm_force_low),
  .phase_enable(phase_enable), .main_phase_disable_n(main_phase_disable_n),
  .shed_phase_disable_n(shed_phase_disable_n), .ctrl_running(ctrl_running));
`default_nettype wire

/* File: vrs_host_model.sv */
// Processor pins and register host facing the supervisor.
`timescale 1ns/10ps
`default_nettype none
module vrs_host_model (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] target_code,
  output logic low_power_state_n,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  // ----
  // Drivers
  // ----
  // Idle bus shows inverted values.
  initial
  begin
    target_code = 8'h40;
    low_power_state_n = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h5A;
    reg_wdata = 8'hA5;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd
  task automatic pins(input logic [7:0] c, input logic lp);
    @(negedge clk);
    target_code = c;
    low_power_state_n = lp;
  endtask : pins
endmodule : vrs_host_model
`default_nettype wire

/* File: test_vr_setpoint_supervisor.sv */
// Self-checking bench for the set-point supervisor.
`timescale 1ns/10ps
`default_nettype none
module test_vr_setpoint_supervisor;
  // ----
  // Cases and signals
  // ----
  localparam int GD = 20;
  typedef struct packed {
    logic [7:0] trim;
    logic [7:0] cal;
    logic [7:0] ghi;
    logic [7:0] glo;
    logic [6:0] ofs;
    logic [1:0] hsel;
    logic [2:0] lsel;
  } vrs_row_s;
  localparam vrs_row_s ROWS [6] = '{
    '{8'h08, 8'h02, 8'h00, 8'h00, 7'h0A, 2'h0, 3'h0},
    '{8'h21, 8'h2E, 8'h01, 8'h01, 7'h71, 2'h1, 3'h1},
    '{8'h0F, 8'h21, 8'h02, 8'h02, 7'h0E, 2'h2, 3'h2},
    '{8'h1F, 8'h1F, 8'h03, 8'h03, 7'h1F, 2'h3, 3'h3},
    '{8'h3F, 8'h3F, 8'hFC, 8'h04, 7'h61, 2'h0, 3'h4},
    '{8'hC8, 8'h00, 8'h00, 8'h07, 7'h08, 2'h0, 3'h7}};
  localparam logic [7:0] ADDRS [6] = '{8'hD1, 8'hD6, 8'hDB, 8'hDC, 8'hE0, 8'hE1};
  localparam logic [7:0] DEFS [6] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  logic clk = 1'b0;
  logic rst_n, en_ok, undervoltage_lockout_ok, ss_done, out_in_window, out_over_limit;
  logic out_below_release, oc_fault, low_power_state_n, reg_wr, reg_rd;
  logic [7:0] target_code, reg_addr, reg_wdata, reg_rdata, target_out, rd_val;
  logic [6:0] offset_steps;
  logic [1:0] good_high_sel;
  logic [2:0] good_low_sel;
  logic [3:0] phase_enable;
  logic power_good_out, pwm_force_low, main_phase_disable_n, shed_phase_disable_n;
  logic ctrl_running;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  vrs_supervisor #(.GOOD_DELAY_CYC(GD)) DUT (.clk(clk), .rst_n(rst_n),
    .target_code(target_code), .low_power_state_n(low_power_state_n),
    .en_ok(en_ok), .undervoltage_lockout_ok(undervoltage_lockout_ok), .ss_done(ss_done),
    .out_in_window(out_in_window), .out_over_limit(out_over_limit),
    .out_below_release(out_below_release), .oc_fault(oc_fault), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .target_out(target_out), .offset_steps(offset_steps),
    .good_high_sel(good_high_sel), .good_low_sel(good_low_sel),
    .power_good_out(power_good_out), .pwm_force_low(pwm_force_low),
    .phase_enable(phase_enable), .main_phase_disable_n(main_phase_disable_n),
    .shed_phase_disable_n(shed_phase_disable_n), .ctrl_running(ctrl_running));
  vrs_host_model host (.clk(clk), .reg_rdata(reg_rdata), .target_code(target_code),
    .low_power_state_n(low_power_state_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  // ----
  // Tasks
  // ----
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wait_for(input logic pg, input logic [7:0] v, input int lim);
    n = 0;
    while ((pg ? {7'h00, power_good_out} : target_out) !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_for
  task automatic report_and_stop();
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  always #50 clk = ~clk;
  // Ceiling is over twice the expected run.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  // ----
  // Sequence
  // ----
  initial
  begin
    rst_n = 1'b0;
    en_ok = 1'b1;
    undervoltage_lockout_ok = 1'b1;
    ss_done = 1'b1;
    out_in_window = 1'b1;
    out_over_limit = 1'b0;
    out_below_release = 1'b1;
    oc_fault = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check("pg_early", {7'h00, power_good_out}, 8'h00);
    foreach (ROWS[i])
    begin
      host.wr(8'hDB, ROWS[i].trim);
      host.wr(8'hDC, ROWS[i].cal);
      host.wr(8'hE0, ROWS[i].ghi);
      host.wr(8'hE1, ROWS[i].glo);
      repeat (3) @(negedge clk);
      check("offset", {1'b0, offset_steps}, {1'b0, ROWS[i].ofs});
      check("hi_sel", {6'h00, good_high_sel}, {6'h00, ROWS[i].hsel});
      check("lo_sel", {5'h00, good_low_sel}, {5'h00, ROWS[i].lsel});
    end
    wait_for(1'b1, 8'h01, 1500);
    check("pg_on", {7'h00, power_good_out}, 8'h01);
    out_in_window = 1'b0;
    repeat (3) @(negedge clk);
    check("pg_win", {7'h00, power_good_out}, 8'h00);
    out_in_window = 1'b1;
    out_below_release = 1'b0;
    out_over_limit = 1'b1;
    repeat (3) @(negedge clk);
    check("crowbar", {6'h00, power_good_out, pwm_force_low}, 8'h03);
    out_over_limit = 1'b0;
    repeat (5) @(negedge clk);
    check("cb_hold", {7'h00, pwm_force_low}, 8'h01);
    out_below_release = 1'b1;
    repeat (3) @(negedge clk);
    check("cb_free", {7'h00, pwm_force_low}, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      host.wr(8'hD1, 8'(c << 6));
      host.pins(8'h40, 1'b0);
      repeat (6) @(negedge clk);
      check("shed", {7'h00, shed_phase_disable_n}, 8'h00);
      check("lp_ph", {4'h0, phase_enable}, (c == 1) ? 8'h05 : 8'h01);
    end
    host.pins(8'h40, 1'b1);
    repeat (6) @(negedge clk);
    check("full_ph", {3'h0, shed_phase_disable_n, phase_enable}, 8'h1F);
    host.pins(8'h41, 1'b1);
    host.pins(8'h40, 1'b1);
    repeat (30) @(negedge clk);
    check("glitch", target_out, 8'h40);
    // Default rate: 12 cycles a step, 16 steps, plus filter delay.
    host.pins(8'h50, 1'b1);
    wait_for(1'b0, 8'h50, 400);
    check("slow_slew", {7'h00, n >= 180 && n <= 210}, 8'h01);
    host.wr(8'hD6, 8'h07);
    host.rd(8'hD6, rd_val);
    check("rate_rd", rd_val, 8'h07);
    host.pins(8'h40, 1'b1);
    wait_for(1'b0, 8'h40, 400);
    check("fast_slew", {7'h00, n >= 60 && n <= 78}, 8'h01);
    host.wr(8'h21, 8'h30);
    host.wr(8'hD2, 8'h08);
    repeat (20) @(negedge clk);
    check("one_sel", target_out, 8'h40);
    host.wr(8'hD3, 8'h08);
    wait_for(1'b0, 8'h30, 200);
    check("bus_tgt", target_out, 8'h30);
    host.wr(8'hD3, 8'h00);
    wait_for(1'b0, 8'h40, 200);
    host.pins(8'hFF, 1'b1);
    repeat (12) @(negedge clk);
    check("no_cpu", {7'h00, power_good_out}, 8'h00);
    host.pins(8'h40, 1'b1);
    wait_for(1'b1, 8'h01, 1500);
    check("pg_back", {7'h00, power_good_out === 1'b1 && n >= 990}, 8'h01);
    host.pins(8'h00, 1'b1);
    repeat (20) @(negedge clk);
    host.pins(8'h40, 1'b1);
    repeat (60) @(negedge clk);
    check("off_brief", {7'h00, ctrl_running}, 8'h01);
    host.pins(8'h01, 1'b1);
    repeat (70) @(negedge clk);
    check("off_long", {6'h00, ctrl_running, pwm_force_low}, 8'h01);
    host.pins(8'h40, 1'b1);
    en_ok = 1'b0;
    repeat (4) @(negedge clk);
    check("en_low", {4'h0, power_good_out, pwm_force_low, main_phase_disable_n,
      shed_phase_disable_n}, 8'h04);
    en_ok = 1'b1;
    repeat (20) @(negedge clk);
    check("restart", {7'h00, ctrl_running}, 8'h01);
    oc_fault = 1'b1;
    @(negedge clk);
    oc_fault = 1'b0;
    repeat (10) @(negedge clk);
    check("oc_latch", {7'h00, ctrl_running}, 8'h00);
    en_ok = 1'b0;
    repeat (3) @(negedge clk);
    en_ok = 1'b1;
    repeat (20) @(negedge clk);
    check("oc_clear", {7'h00, ctrl_running}, 8'h01);
    undervoltage_lockout_ok = 1'b0;
    repeat (4) @(negedge clk);
    check("undervoltage_lockout_low", {6'h00, ctrl_running, pwm_force_low}, 8'h01);
    undervoltage_lockout_ok = 1'b1;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    check("rst_pwm", {7'h00, pwm_force_low}, 8'h01);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    foreach (ADDRS[i])
    begin
      host.rd(ADDRS[i], rd_val);
      check("default", rd_val, DEFS[i]);
    end
    host.wr(8'h55, 8'hAA);
    host.rd(8'h55, rd_val);
    check("unmapped", rd_val, 8'h00);
    report_and_stop();
  end
endmodule : test_vr_setpoint_supervisor
`default_nettype wire
